// ---- src/bsfr_map.svh ----
/*
  Offsets, implemented-bit masks and reset values of the bank 0 special
  register file. Assumes it is included by its bare name from design files.
*/
`ifndef BSFR_MAP_SVH
`define BSFR_MAP_SVH

// ************************************************************
// Register offsets within a bank (low five address bits).
// ************************************************************
`define BSFR_OFS_INDIRECT_DATA   5'h00
`define BSFR_OFS_TIMER0_COUNT    5'h01
`define BSFR_OFS_PC_LOW          5'h02
`define BSFR_OFS_STATUS          5'h03
`define BSFR_OFS_INDIRECT_PTR    5'h04
`define BSFR_OFS_PORT_A          5'h05
`define BSFR_OFS_PORT_B          5'h06
`define BSFR_OFS_PORT_C          5'h07
`define BSFR_OFS_PC_UPPER_LATCH  5'h0A
`define BSFR_OFS_INT_CONTROL     5'h0B
`define BSFR_OFS_PERIPH_FLAGS    5'h0C
`define BSFR_OFS_TIMER1_LOW      5'h0E
`define BSFR_OFS_TIMER1_HIGH     5'h0F
`define BSFR_OFS_TIMER1_CONTROL  5'h10
`define BSFR_OFS_TIMER2_COUNT    5'h11
`define BSFR_OFS_TIMER2_CONTROL  5'h12
`define BSFR_OFS_SERIAL_BUFFER   5'h13
`define BSFR_OFS_SERIAL_CONTROL  5'h14
`define BSFR_OFS_CAPTURE_LOW     5'h15
`define BSFR_OFS_CAPTURE_HIGH    5'h16
`define BSFR_OFS_CAPTURE_CONTROL 5'h17
`define BSFR_OFS_CONV_RESULT     5'h1E
`define BSFR_OFS_CONV_CONTROL    5'h1F

// ************************************************************
// Address space limits.
// ************************************************************
`define BSFR_SFR_TOP             7'h1F

// ************************************************************
// Implemented bits (unimplemented bits read as zero).
// ************************************************************
`define BSFR_MASK_FULL           8'hFF
`define BSFR_MASK_PORT_A         8'h3F
`define BSFR_MASK_PC_UPPER       8'h1F
`define BSFR_MASK_PERIPH_FLAGS   8'h7F
`define BSFR_MASK_TIMER1_CONTROL 8'h3F
`define BSFR_MASK_TIMER2_CONTROL 8'h7F
`define BSFR_MASK_CAPTURE_CTRL   8'h3F
`define BSFR_MASK_CONV_CONTROL   8'hFD
`define BSFR_MASK_CONV_FLAG      8'h40

// ************************************************************
// Status field positions.
// ************************************************************
`define BSFR_STATUS_IND_BANK     7
`define BSFR_STATUS_BANK_HI      6
`define BSFR_STATUS_BANK_LO      5
`define BSFR_STATUS_TIMEOUT      4
`define BSFR_STATUS_POWER_DOWN   3

// ************************************************************
// Power-on / brown-out values; unknown bits are taken as zero.
// ************************************************************
`define BSFR_POR_ZERO            8'h00
`define BSFR_POR_STATUS          8'h18

// ************************************************************
// Bits kept unchanged through the pin or watchdog reset.
// ************************************************************
`define BSFR_KEEP_ALL            8'hFF
`define BSFR_KEEP_NONE           8'h00
`define BSFR_KEEP_STATUS         8'h07
`define BSFR_KEEP_PORT_A         8'h10
`define BSFR_KEEP_INT_CONTROL    8'h01

`endif

// ---- src/bsfr_pkg.sv ----
/*
  Types shared by the bank 0 special register file.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bsfr_pkg;

  // ************************************************************
  // Data memory bank codes.
  // ************************************************************
  typedef enum logic [1:0] {
    BSFR_BANK0 = 2'b00,
    BSFR_BANK1 = 2'b01,
    BSFR_BANK2 = 2'b10,
    BSFR_BANK3 = 2'b11
  } bsfr_bank_e;

  typedef logic [7:0] bsfr_byte_t;

endpackage : bsfr_pkg

// ---- src/bsfr_pin_sync.sv ----
/*
  Two-stage synchroniser for a group of port pins.
  Assumes the pins are asynchronous to clock; only the second stage is read.
*/
`timescale 1ns/10ps
module bsfr_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,              // Core clock.
  input wire logic rst,                // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels.
  output logic [WIDTH-1:0] pin_sync    // Synchronised pin levels.
);

  // ************************************************************
  // One two-flop chain per pin.
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic stage1_reg;
      logic stage2_reg;
      // The first stage feeds only the second, to keep metastability contained.
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end
        else
        begin
          stage1_reg <= pin_in[g];
          stage2_reg <= stage1_reg;
        end
      end
      assign pin_sync[g] = stage2_reg;
    end
  endgenerate

endmodule : bsfr_pin_sync

// ---- src/bsfr_regfile.sv ----
/*
  Bank 0 special register file: core and peripheral registers, indirect
  access, bank mirrors, program counter with upper-bits latch, port latches.
  Assumes a core datapath on the same clock that issues one access per cycle,
  and a reset controller giving a one-cycle pin/watchdog reset pulse.
*/
`timescale 1ns/10ps
`include "bsfr_map.svh"
module bsfr_regfile #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input wire logic clock,                  // Core clock, 200 MHz.
  input wire logic rst,                    // Power-on / brown-out reset, async.
  input wire logic other_rst,              // Pin or watchdog reset, one-cycle pulse.
  input wire logic rst_timeout_flag,       // Timeout flag value for other reset.
  input wire logic rst_power_down_flag,    // Power-down flag value for other reset.
  input wire logic [6:0] file_addr,        // Direct file address from instruction.
  input wire logic rd_en,                  // Read request.
  input wire logic wr_en,                  // Write request.
  input wire logic [7:0] wr_data,          // Write data.
  output logic [7:0] rd_data,              // Read data, one cycle after rd_en.
  output logic rd_hit,                     // Address belongs to this block.
  input wire logic alu_flags_we,           // ALU updates zero, digit carry, carry.
  input wire logic [2:0] alu_flags,        // New zero, digit carry, carry.
  input wire logic pc_step,                // Advance the program counter.
  input wire logic pc_jump,                // Branch to jump_target.
  input wire logic [10:0] jump_target,     // Branch target low bits.
  output logic [12:0] pc_out,              // Program counter.
  output logic [7:0] status_out,           // Arithmetic and bank status.
  input wire logic [7:0] periph_flag_set,  // Peripheral event flag set pulses.
  input wire logic [2:0] int_flag_set,     // Core interrupt flag set pulses.
  output logic [7:0] int_control_out,      // Interrupt control register.
  output logic [7:0] periph_flags_out,     // Peripheral flag register.
  input wire logic conv_load,              // Converter result strobe.
  input wire logic [7:0] conv_value,       // Converter result value.
  input wire logic [5:0] port_a_pin_in,    // Port A pin levels.
  input wire logic [7:0] port_b_pin_in,    // Port B pin levels.
  input wire logic [7:0] port_c_pin_in,    // Port C pin levels.
  input wire logic [5:0] port_a_drive,     // Port A direction, 1 drives.
  input wire logic [7:0] port_b_drive,     // Port B direction, 1 drives.
  input wire logic [7:0] port_c_drive,     // Port C direction, 1 drives.
  output logic [5:0] port_a_pin_out,       // Port A output latch.
  output logic [7:0] port_b_pin_out,       // Port B output latch.
  output logic [7:0] port_c_pin_out,       // Port C output latch.
  output logic [5:0] port_a_pin_oe,        // Port A output enable.
  output logic [7:0] port_b_pin_oe,        // Port B output enable.
  output logic [7:0] port_c_pin_oe         // Port C output enable.
);

  // ************************************************************
  // Per-location constants.
  // ************************************************************

  // Implemented bits; zero marks a location with no storage.
  function automatic logic [7:0] impl_mask(input logic [4:0] idx);
    logic [7:0] m;
    m = 8'h00;
    case (idx)
      `BSFR_OFS_TIMER0_COUNT,
      `BSFR_OFS_STATUS,
      `BSFR_OFS_INDIRECT_PTR,
      `BSFR_OFS_PORT_B,
      `BSFR_OFS_PORT_C,
      `BSFR_OFS_INT_CONTROL,
      `BSFR_OFS_TIMER1_LOW,
      `BSFR_OFS_TIMER1_HIGH,
      `BSFR_OFS_TIMER2_COUNT,
      `BSFR_OFS_SERIAL_BUFFER,
      `BSFR_OFS_SERIAL_CONTROL,
      `BSFR_OFS_CAPTURE_LOW,
      `BSFR_OFS_CAPTURE_HIGH:      m = `BSFR_MASK_FULL;
      `BSFR_OFS_PORT_A:            m = `BSFR_MASK_PORT_A;
      `BSFR_OFS_PC_UPPER_LATCH:    m = `BSFR_MASK_PC_UPPER;
      `BSFR_OFS_PERIPH_FLAGS:      m = HAS_CONVERTER ? `BSFR_MASK_PERIPH_FLAGS
                                       : (`BSFR_MASK_PERIPH_FLAGS & ~`BSFR_MASK_CONV_FLAG);
      `BSFR_OFS_TIMER1_CONTROL:    m = `BSFR_MASK_TIMER1_CONTROL;
      `BSFR_OFS_TIMER2_CONTROL:    m = `BSFR_MASK_TIMER2_CONTROL;
      `BSFR_OFS_CAPTURE_CONTROL:   m = `BSFR_MASK_CAPTURE_CTRL;
      `BSFR_OFS_CONV_RESULT:       m = HAS_CONVERTER ? `BSFR_MASK_FULL : 8'h00;
      `BSFR_OFS_CONV_CONTROL:      m = HAS_CONVERTER ? `BSFR_MASK_CONV_CONTROL : 8'h00;
      default:                     m = 8'h00;
    endcase
    return m;
  endfunction : impl_mask

  // Bits that survive a pin or watchdog reset.
  function automatic logic [7:0] keep_mask(input logic [4:0] idx);
    logic [7:0] k;
    k = `BSFR_KEEP_NONE;
    case (idx)
      `BSFR_OFS_TIMER0_COUNT,
      `BSFR_OFS_INDIRECT_PTR,
      `BSFR_OFS_PORT_B,
      `BSFR_OFS_PORT_C,
      `BSFR_OFS_TIMER1_LOW,
      `BSFR_OFS_TIMER1_HIGH,
      `BSFR_OFS_TIMER1_CONTROL,
      `BSFR_OFS_SERIAL_BUFFER,
      `BSFR_OFS_CAPTURE_LOW,
      `BSFR_OFS_CAPTURE_HIGH,
      `BSFR_OFS_CONV_RESULT:     k = `BSFR_KEEP_ALL;
      `BSFR_OFS_STATUS:          k = `BSFR_KEEP_STATUS;
      `BSFR_OFS_PORT_A:          k = `BSFR_KEEP_PORT_A;
      `BSFR_OFS_INT_CONTROL:     k = `BSFR_KEEP_INT_CONTROL;
      default:                   k = `BSFR_KEEP_NONE;
    endcase
    return k;
  endfunction : keep_mask

  // Power-on value; unknown contents are held at zero for determinism.
  function automatic logic [7:0] por_value(input logic [4:0] idx);
    return (idx == `BSFR_OFS_STATUS) ? `BSFR_POR_STATUS : `BSFR_POR_ZERO;
  endfunction : por_value

  // ************************************************************
  // State.
  // ************************************************************
  logic [7:0] sfr_reg [0:31];
  logic [7:0] sfr_next [0:31];
  logic [12:0] pc_reg;
  logic [12:0] pc_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_hit_reg;
  logic rd_hit_next;
  logic [21:0] oe_reg;
  logic [21:0] oe_next;

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  logic [21:0] pins_raw;
  logic [21:0] pins_sync;

  assign pins_raw = {port_c_pin_in, port_b_pin_in, port_a_pin_in};

  bsfr_pin_sync #(
    .WIDTH(22)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .pin_in(pins_raw),
    .pin_sync(pins_sync)
  );

  // ************************************************************
  // Address resolution.
  // ************************************************************
  logic ind_access;
  bsfr_pkg::bsfr_bank_e eff_bank;
  logic [6:0] eff_addr;
  logic eff_hit;
  logic [4:0] eff_idx;
  logic [7:0] status_cur;
  logic [7:0] pointer_cur;

  assign status_cur = sfr_reg[`BSFR_OFS_STATUS];
  assign pointer_cur = sfr_reg[`BSFR_OFS_INDIRECT_PTR];

  // Location zero redirects through the pointer; the indirect-bank bit is
  // reserved but still steers, so software that sets it reaches nothing here.
  always_comb
  begin
    ind_access = (file_addr == 7'h00);
    if (ind_access)
    begin
      eff_bank = bsfr_pkg::bsfr_bank_e'({status_cur[`BSFR_STATUS_IND_BANK],
                                         pointer_cur[7]});
      eff_addr = pointer_cur[6:0];
    end
    else
    begin
      eff_bank = bsfr_pkg::bsfr_bank_e'(status_cur[`BSFR_STATUS_BANK_HI:`BSFR_STATUS_BANK_LO]);
      eff_addr = file_addr;
    end
    eff_idx = eff_addr[4:0];
    case (eff_bank)
      bsfr_pkg::BSFR_BANK0: eff_hit = (eff_addr <= `BSFR_SFR_TOP);
      bsfr_pkg::BSFR_BANK1:
      begin
        // Only the high-use core registers are mirrored into bank 1.
        eff_hit = (eff_addr <= `BSFR_SFR_TOP) &&
                  (eff_idx == `BSFR_OFS_INDIRECT_DATA || eff_idx == `BSFR_OFS_PC_LOW ||
                   eff_idx == `BSFR_OFS_STATUS || eff_idx == `BSFR_OFS_INDIRECT_PTR ||
                   eff_idx == `BSFR_OFS_PC_UPPER_LATCH ||
                   eff_idx == `BSFR_OFS_INT_CONTROL);
      end
      bsfr_pkg::BSFR_BANK2: eff_hit = 1'b0;
      bsfr_pkg::BSFR_BANK3: eff_hit = 1'b0;
      default:              eff_hit = 1'b0;
    endcase
    // An indirect access that points at location zero reaches no register.
    if (ind_access && eff_idx == `BSFR_OFS_INDIRECT_DATA)
    begin
      eff_hit = 1'b0;
    end
  end

  // ************************************************************
  // Read path: value as seen before this cycle's write.
  // ************************************************************
  always_comb
  begin
    rd_data_next = 8'h00;
    rd_hit_next = 1'b0;
    if (rd_en && !other_rst)
    begin
      rd_hit_next = eff_hit;
      if (eff_hit)
      begin
        case (eff_idx)
          `BSFR_OFS_PC_LOW: rd_data_next = pc_reg[7:0];
          `BSFR_OFS_PORT_A: rd_data_next = {2'b00, pins_sync[5:0]};
          `BSFR_OFS_PORT_B: rd_data_next = pins_sync[13:6];
          `BSFR_OFS_PORT_C: rd_data_next = pins_sync[21:14];
          default:          rd_data_next = sfr_reg[eff_idx] & impl_mask(eff_idx);
        endcase
      end
    end
  end

  // ************************************************************
  // Register file next state.
  // ************************************************************
  logic wr_hit;

  assign wr_hit = wr_en && eff_hit;

  // Hardware flag sets are ORed after the software write so a set in the
  // same cycle as a clear is never lost.
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      sfr_next[i] = sfr_reg[i];
      if (wr_hit && eff_idx == 5'(i) && 5'(i) != `BSFR_OFS_CONV_RESULT)
      begin
        sfr_next[i] = wr_data & impl_mask(5'(i));
      end
    end
    // Port writes only ever reach the latch; reads go to the pins.
    // Timeout and power-down are not writable.
    sfr_next[`BSFR_OFS_STATUS][`BSFR_STATUS_TIMEOUT:`BSFR_STATUS_POWER_DOWN] =
      status_cur[`BSFR_STATUS_TIMEOUT:`BSFR_STATUS_POWER_DOWN];
    // An instruction that sets the arithmetic flags overrides its own write.
    if (alu_flags_we)
    begin
      sfr_next[`BSFR_OFS_STATUS][2:0] = alu_flags;
    end
    sfr_next[`BSFR_OFS_PERIPH_FLAGS] = sfr_next[`BSFR_OFS_PERIPH_FLAGS] |
      (periph_flag_set & impl_mask(`BSFR_OFS_PERIPH_FLAGS));
    sfr_next[`BSFR_OFS_INT_CONTROL][2:0] =
      sfr_next[`BSFR_OFS_INT_CONTROL][2:0] | int_flag_set;
    if (conv_load && HAS_CONVERTER)
    begin
      sfr_next[`BSFR_OFS_CONV_RESULT] = conv_value;
    end
    // Pin or watchdog reset overrides everything else.
    if (other_rst)
    begin
      for (int i = 0; i < 32; i++)
      begin
        sfr_next[i] = sfr_reg[i] & keep_mask(5'(i));
      end
      sfr_next[`BSFR_OFS_STATUS][`BSFR_STATUS_TIMEOUT] = rst_timeout_flag;
      sfr_next[`BSFR_OFS_STATUS][`BSFR_STATUS_POWER_DOWN] = rst_power_down_flag;
    end
  end

  // ************************************************************
  // Program counter.
  // ************************************************************

  // The upper bits are never written directly; they come from the latch
  // when the low byte is written, and only the top two come from it on a jump.
  always_comb
  begin
    pc_next = pc_reg;
    if (other_rst)
    begin
      pc_next = 13'h0000;
    end
    else if (wr_hit && eff_idx == `BSFR_OFS_PC_LOW)
    begin
      pc_next = {sfr_reg[`BSFR_OFS_PC_UPPER_LATCH][4:0], wr_data};
    end
    else if (pc_jump)
    begin
      pc_next = {sfr_reg[`BSFR_OFS_PC_UPPER_LATCH][4:3], jump_target};
    end
    else if (pc_step)
    begin
      pc_next = pc_reg + 13'h0001;
    end
  end

  // ************************************************************
  // Port output enables.
  // ************************************************************

  // Enables follow the direction inputs, but are forced off in the cycle after a pin or
  // watchdog reset pulse and throughout power-on reset, so the pins float regardless of latch contents.
  always_comb
  begin
    if (other_rst)
    begin
      oe_next = 22'h000000;
    end
    else
    begin
      oe_next = {port_c_drive, port_b_drive, port_a_drive};
    end
  end

  // ************************************************************
  // Registers.
  // ************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
      begin
        sfr_reg[i] <= por_value(5'(i));
      end
      pc_reg <= 13'h0000;
      rd_data_reg <= 8'h00;
      rd_hit_reg <= 1'b0;
      oe_reg <= 22'h000000;
    end
    else
    begin
      for (int i = 0; i < 32; i++)
      begin
        sfr_reg[i] <= sfr_next[i];
      end
      pc_reg <= pc_next;
      rd_data_reg <= rd_data_next;
      rd_hit_reg <= rd_hit_next;
      oe_reg <= oe_next;
    end
  end

  // ************************************************************
  // Outputs, all straight from flops.
  // ************************************************************
  assign rd_data = rd_data_reg;
  assign rd_hit = rd_hit_reg;
  assign pc_out = pc_reg;
  assign status_out = sfr_reg[`BSFR_OFS_STATUS];
  assign int_control_out = sfr_reg[`BSFR_OFS_INT_CONTROL];
  assign periph_flags_out = sfr_reg[`BSFR_OFS_PERIPH_FLAGS];
  assign port_a_pin_out = sfr_reg[`BSFR_OFS_PORT_A][5:0];
  assign port_b_pin_out = sfr_reg[`BSFR_OFS_PORT_B];
  assign port_c_pin_out = sfr_reg[`BSFR_OFS_PORT_C];
  assign port_a_pin_oe = oe_reg[5:0];
  assign port_b_pin_oe = oe_reg[13:6];
  assign port_c_pin_oe = oe_reg[21:14];

endmodule : bsfr_regfile

// ---- test/bsfr_regfile_props.sv ----
/*
  Port checks of the bank 0 register file.
  Assumes a bind onto bsfr_regfile, one clock domain.
*/
`timescale 1ns/10ps
module bsfr_regfile_props (
  input wire logic clock, // Clock.
  input wire logic rst, // Power-on reset.
  input wire logic other_rst, // Pin reset.
  input wire logic rst_timeout_flag, // Cause.
  input wire logic rst_power_down_flag, // Cause.
  input wire logic [6:0] file_addr, // Address.
  input wire logic rd_en, // Read.
  input wire logic wr_en, // Write.
  input wire logic [7:0] wr_data, // Data in.
  input wire logic [7:0] rd_data, // Data out.
  input wire logic rd_hit, // Hit.
  input wire logic pc_step, // Step.
  input wire logic pc_jump, // Jump.
  input wire logic [12:0] pc_out, // Counter.
  input wire logic [7:0] status_out, // Status.
  input wire logic [7:0] port_b_pin_out, // Latch.
  input wire logic [7:0] port_b_pin_oe // Enable.
);
  // One domain, so clock and power-on reset are given once.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // The cycle right after a pin reset pulse.
  sequence pin_reset;
    other_rst ##1 1'b1;
  endsequence
  chk_idle_read: assert property (!rd_en |=> rd_data == 8'h00 && !rd_hit)
    else $error("Read data without a read.");
  chk_status_cause: assert property (pin_reset |-> status_out[7:3] ==
    {3'b000, $past(rst_timeout_flag), $past(rst_power_down_flag)})
    else $error("Status after pin reset wrong.");
  chk_pins_input: assert property (pin_reset |-> port_b_pin_oe == 8'h00)
    else $error("Pins driven after reset.");
  chk_pc_cleared: assert property (pin_reset |-> pc_out == 13'h0000)
    else $error("Counter not cleared.");
  chk_pc_low: assert property (wr_en && file_addr == 7'h02 && !other_rst
    && !status_out[6] |=> pc_out[7:0] == $past(wr_data)) else $error("Counter low wrong.");
  chk_pc_advance: assert property (pc_step && !pc_jump && !wr_en && !other_rst
    |=> pc_out == $past(pc_out) + 13'h0001) else $error("Counter step wrong.");
  chk_port_latch: assert property (wr_en && file_addr == 7'h06 && !other_rst
    && status_out[6:5] == 2'b00 |=> port_b_pin_out == $past(wr_data))
    else $error("Port latch wrong.");
  chk_unimpl_zero: assert property (rd_en && file_addr inside {7'h08, 7'h09, 7'h0D}
    && !other_rst && status_out[6:5] == 2'b00 |=> rd_hit && rd_data == 8'h00)
    else $error("Unused place not zero.");
endmodule : bsfr_regfile_props
bind bsfr_regfile bsfr_regfile_props u_props (.clock, .rst, .other_rst, .rst_timeout_flag,
  .rst_power_down_flag, .file_addr, .rd_en, .wr_en, .wr_data, .rd_data, .rd_hit, .pc_step,
  .pc_jump, .pc_out, .status_out, .port_b_pin_out, .port_b_pin_oe);

// ---- test/bsfr_core_model.sv ----
/*
  Core datapath model issuing direct-address reads and writes.
  Assumes read data is valid 1 ns after the taking edge.
*/
`timescale 1ns/10ps
module bsfr_core_model (
  input wire logic clock, // Clock.
  input wire logic [7:0] rd_data, // Data out.
  input wire logic rd_hit, // Hit.
  output logic [6:0] file_addr, // Address.
  output logic rd_en, // Read.
  output logic wr_en, // Write.
  output logic [7:0] wr_data // Data in.
);
  // Idle at time zero.
  initial
  begin
    {file_addr, rd_en, wr_en, wr_data} = '0;
  end
  // Released lines are inverted so a stale value never looks valid.
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    file_addr = a;
    wr_data = (a == 7'h03) ? (d & 8'h3F) : d;
    wr_en = 1'b1;
    @(posedge clock);
    #1;
    wr_en = 1'b0;
    file_addr = ~file_addr;
    wr_data = ~wr_data;
  endtask : wr
  // The answer is taken 1 ns after the taking edge.
  task rd(input logic [6:0] a, output logic [7:0] d, output logic h);
    @(posedge clock);
    #1;
    file_addr = a;
    rd_en = 1'b1;
    @(posedge clock);
    #1;
    rd_en = 1'b0;
    file_addr = ~file_addr;
    d = rd_data;
    h = rd_hit;
  endtask : rd
endmodule : bsfr_core_model

// ---- test/bsfr_regfile_test.sv ----
/*
  Directed test of the bank 0 register file through the core model.
  Assumes a 200 MHz clock and power-on reset held four cycles.
*/
`timescale 1ns/10ps
module bsfr_regfile_test;
  logic clock, rst, other_rst, rst_timeout_flag, rst_power_down_flag, rd_en, wr_en, rd_hit;
  logic alu_flags_we, pc_step, pc_jump, conv_load, h;
  logic [6:0] file_addr;
  logic [7:0] wr_data, rd_data, status_out, int_control_out, periph_flags_out, d;
  logic [7:0] periph_flag_set, conv_value, port_b_pin_in, port_c_pin_in, port_b_drive;
  logic [7:0] port_c_drive, port_b_pin_out, port_c_pin_out, port_b_pin_oe, port_c_pin_oe;
  logic [5:0] port_a_pin_in, port_a_drive, port_a_pin_out, port_a_pin_oe;
  logic [2:0] alu_flags, int_flag_set;
  logic [10:0] jump_target;
  logic [12:0] pc_out;
  logic [6:0] unused_loc [5] = '{7'h08, 7'h09, 7'h0D, 7'h18, 7'h1D};
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  bsfr_regfile uut (.clock, .rst, .other_rst, .rst_timeout_flag, .rst_power_down_flag,
    .file_addr, .rd_en, .wr_en, .wr_data, .rd_data, .rd_hit, .alu_flags_we, .alu_flags,
    .pc_step, .pc_jump, .jump_target, .pc_out, .status_out, .periph_flag_set, .int_flag_set,
    .int_control_out, .periph_flags_out, .conv_load, .conv_value, .port_a_pin_in,
    .port_b_pin_in, .port_c_pin_in, .port_a_drive, .port_b_drive, .port_c_drive,
    .port_a_pin_out, .port_b_pin_out, .port_c_pin_out, .port_a_pin_oe, .port_b_pin_oe,
    .port_c_pin_oe);
  bsfr_core_model core (.clock, .rd_data, .rd_hit, .file_addr, .rd_en, .wr_en, .wr_data);
  // Free-running 5 ns clock.
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // A hang is cut short well past the roughly 70 cycles the test needs.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      results();
    end
  end
  task tick;
    @(posedge clock);
    #1;
  endtask : tick
  task chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task results;
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  // Main sequence; flag sets pulse only in the set-against-clear step.
  initial
  begin
    rst = 1'b1;
    {other_rst, rst_timeout_flag, rst_power_down_flag, alu_flags_we, pc_step, pc_jump} = '0;
    {conv_load, alu_flags, int_flag_set, periph_flag_set, conv_value, jump_target} = '0;
    {port_a_pin_in, port_b_pin_in, port_c_pin_in, port_a_drive, port_b_drive} = '0;
    port_c_drive = 8'h00;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    core.rd(7'h03, d, h);
    chk(d, 8'h18);
    core.wr(7'h0A, 8'hF5);
    core.wr(7'h02, 8'h34);
    chk(pc_out, 13'h1534);
    jump_target = 11'h7FF;
    pc_jump = 1'b1;
    tick();
    pc_jump = 1'b0;
    pc_step = 1'b1;
    chk(pc_out, 13'h17FF);
    tick();
    pc_step = 1'b0;
    chk(pc_out, 13'h1800);
    foreach (unused_loc[i])
    begin
      core.wr(unused_loc[i], 8'hFF);
      core.rd(unused_loc[i], d, h);
      chk({h, d}, 9'h100);
    end
    core.rd(7'h20, d, h);
    chk(h, 1'b0);
    core.wr(7'h03, 8'hFF);
    chk(status_out, 8'h3F);
    core.rd(7'h0A, d, h);
    chk({h, d}, 9'h115);
    core.rd(7'h05, d, h);
    chk(h, 1'b0);
    core.wr(7'h0B, 8'h80);
    core.wr(7'h03, 8'h05);
    chk(status_out, 8'h1D);
    core.wr(7'h04, 8'h0B);
    core.rd(7'h00, d, h);
    chk(d, 8'h80);
    {port_a_drive, port_b_drive, port_c_drive} = 22'h3FFFFF;
    {port_a_pin_in, port_b_pin_in, port_c_pin_in} = {6'h2A, 8'h3C, 8'h81};
    core.wr(7'h06, 8'hA5);
    chk(port_b_pin_out, 8'hA5);
    core.wr(7'h05, 8'hFF);
    chk(port_a_pin_out, 6'h3F);
    core.rd(7'h05, d, h);
    chk(d, 8'h2A);
    core.rd(7'h06, d, h);
    chk(d, 8'h3C);
    core.rd(7'h07, d, h);
    chk(d, 8'h81);
    periph_flag_set = 8'h81;
    int_flag_set = 3'h4;
    core.wr(7'h0C, 8'h00);
    {periph_flag_set, int_flag_set} = '0;
    chk(periph_flags_out, 8'h01);
    chk(int_control_out, 8'h84);
    conv_value = 8'h5A;
    conv_load = 1'b1;
    tick();
    conv_load = 1'b0;
    rst_power_down_flag = 1'b1;
    other_rst = 1'b1;
    tick();
    other_rst = 1'b0;
    chk(status_out, 8'h0D);
    chk(port_b_pin_oe, 8'h00);
    chk(port_a_pin_oe, 6'h00);
    chk(port_c_pin_oe, 8'h00);
    chk(port_b_pin_out, 8'hA5);
    chk(port_a_pin_out, 6'h10);
    chk(port_c_pin_out, 8'h00);
    chk(int_control_out, 8'h00);
    chk(periph_flags_out, 8'h00);
    chk(pc_out, 13'h0000);
    core.rd(7'h04, d, h);
    chk(d, 8'h0B);
    core.rd(7'h1E, d, h);
    chk(d, 8'h5A);
    core.rd(7'h0A, d, h);
    chk(d, 8'h00);
    results();
  end
endmodule : bsfr_regfile_test
